// ==== src/vic_pkg.sv ====
package vic_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int NUM_VEC = 32;
   localparam int VEC_W = 5;
   localparam int PRIO_W = 3;
   localparam int NEST_DEPTH = 8;
   localparam int DEPTH_W = 4;
   localparam int ISR_AW = 16;
   localparam int REG_AW = 8;
   localparam int CNT_W = 3;

   // ------------------------------------------------------------
   // timing in clocks of hclk
   // ------------------------------------------------------------
   localparam int EVAL_CYCLES = 3;
   localparam int BRANCH_CYCLES = 7;
   localparam logic [CNT_W-1:0] EVAL_LAST = CNT_W'(EVAL_CYCLES - 2);
   localparam logic [CNT_W-1:0] BRANCH_LAST = CNT_W'(BRANCH_CYCLES - 1);

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [REG_AW-1:0] OFS_ENABLE = 8'h00;
   localparam logic [REG_AW-1:0] OFS_SET_PENDING_FLAG = 8'h04;
   localparam logic [REG_AW-1:0] OFS_CLR_PENDING_FLAG = 8'h08;
   localparam logic [REG_AW-1:0] OFS_ACTIVE = 8'h0C;
   localparam logic [REG_AW-1:0] OFS_SRC_LO = 8'h10;
   localparam logic [REG_AW-1:0] OFS_SRC_HI = 8'h14;
   localparam logic [REG_AW-1:0] OFS_PRIO0 = 8'h20;
   localparam logic [REG_AW-1:0] OFS_PRIO3 = 8'h2C;
   localparam logic [REG_AW-1:0] OFS_ISR_BASE = 8'h80;

   // ------------------------------------------------------------
   // field layout and reset values
   // ------------------------------------------------------------
   localparam int SRC_FLD_W = 2;
   localparam int PRIO_FLD_W = 4;
   localparam int ACT_DEPTH_POS = 12;
   localparam int ACT_PRIO_POS = 8;
   localparam int ACT_VEC_POS = 0;
   localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
   localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;
   localparam logic [ISR_AW-1:0] ISR_RST = 16'h0000;

   localparam logic [1:0] SRC_FIXED = 2'h0;
   localparam logic [1:0] SRC_DMA = 2'h1;
   localparam logic [1:0] SRC_LOGIC = 2'h2;
   localparam logic [1:0] SRC_NONE = 2'h3;
   localparam logic [1:0] SRC_RST = SRC_FIXED;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_EVAL,
      ST_REQ,
      ST_CLR_PENDING_FLAG,
      ST_CLR_POSTED_FLAG,
      ST_BRANCH
   } ctl_state_t;

   // level 0 is the most urgent
   function automatic logic higher_prio(input logic [PRIO_W-1:0] a,
                                        input logic [PRIO_W-1:0] b);
      return a < b;
   endfunction

endpackage

// ==== src/irq_source_mux.sv ====
`timescale 1ns/1ps
module irq_source_mux (
   input wire logic [63:0] sel,
   input wire logic [31:0] fixed_irq,
   input wire logic [15:0] dma_term0,
   input wire logic [15:0] dma_term1,
   input wire logic [31:0] logic_irq,
   output logic [31:0] line
);
   // ------------------------------------------------------------
   // per-vector source choice
   // ------------------------------------------------------------
   logic [31:0] dma_line;

   assign dma_line = {dma_term1, dma_term0};

   always_comb begin
      for (int i = 0; i < vic_pkg::NUM_VEC; i++) begin
         case (sel[2*i +: 2])
            vic_pkg::SRC_FIXED: line[i] = fixed_irq[i];
            vic_pkg::SRC_DMA: line[i] = dma_line[i];
            vic_pkg::SRC_LOGIC: line[i] = logic_irq[i];
            default: line[i] = 1'b0;
         endcase
      end
   end
endmodule // irq_source_mux

// ==== src/irq_prio_arbiter.sv ====
`timescale 1ns/1ps
module irq_prio_arbiter (
   input wire logic [31:0] req,
   input wire logic [95:0] prio,
   output logic win_valid,
   output logic [4:0] win_vec,
   output logic [2:0] win_prio
);
   // ------------------------------------------------------------
   // lowest level wins, ties to lowest vector
   // ------------------------------------------------------------
   always_comb begin
      win_valid = 1'b0;
      win_vec = 5'h00;
      win_prio = 3'h7;
      // ascending scan with strict compare keeps the lower vector on a tie
      for (int i = 0; i < vic_pkg::NUM_VEC; i++) begin
         if (req[i] && (!win_valid ||
             vic_pkg::higher_prio(prio[3*i +: 3], win_prio))) begin
            win_valid = 1'b1;
            win_vec = 5'(i);
            win_prio = prio[3*i +: 3];
         end
      end
   end
endmodule // irq_prio_arbiter

// ==== src/vectored_interrupt_controller.sv ====
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
// Function
// - thirty-two vectors, each fed from several possible sources
// - each vector has its own enable bit
// - software sets each vector's priority at run time, eight levels
// - service routines nest up to eight deep
// - software can raise any interrupt and clear a pending one
// - per-vector routine address, writable at run time, handed to cpu
// - equal priority: smaller vector number served first
// - each vector picks fixed line, dma channel or logic array line
// - dma kind uses the two interrupt outputs of each channel
// - logic array path lets any signal reach any vector
// - pending flag set on next clock edge after arrival
// - posted flag set in the stage after pending
// - evaluation plus request take three clocks, vector number sent
// - routine address posted; cpu acknowledges and reads it
// - on acknowledge clear pending, then posted
// - acknowledge phase ends after seven cycles, then routine runs
// - on completion restore previous active status
module vectored_interrupt_controller #(
   parameter int ISR_AW = vic_pkg::ISR_AW
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [31:0] fixed_irq,
   input wire logic [15:0] dma_term0,
   input wire logic [15:0] dma_term1,
   input wire logic [31:0] logic_irq,
   output logic irq_req,
   output logic [4:0] irq_vector,
   output logic [ISR_AW-1:0] isr_addr,
   input wire logic irq_acknowledge,
   input wire logic isr_complete
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [31:0] enable_q, enable_d;
   logic [63:0] src_sel_q, src_sel_d;
   logic [95:0] prio_q, prio_d;
   logic [ISR_AW-1:0] isr_q [32];
   logic [ISR_AW-1:0] isr_d [32];
   logic wr_pending_flag_q, wr_pending_flag_d;
   logic [7:0] wr_addr_q, wr_addr_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic [31:0] rd_word;
   logic [31:0] sw_set, sw_clr;

   logic [31:0] line, line_q;
   logic [31:0] pending_flag_q, pending_flag_d;
   logic [31:0] posted_flag_q, posted_flag_d;
   logic [31:0] ack_clr, posted_flag_clr, elig;
   logic win_valid;
   logic [4:0] win_vec;
   logic [2:0] win_prio;

   vic_pkg::ctl_state_t state_q, state_d;
   logic [vic_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [4:0] cur_vec_q, cur_vec_d;
   logic [2:0] cur_prio_q, cur_prio_d;
   logic [ISR_AW-1:0] isr_out_q, isr_out_d;
   logic push;

   logic [4:0] stack_vec_q [8];
   logic [4:0] stack_vec_d [8];
   logic [2:0] stack_prio_q [8];
   logic [2:0] stack_prio_d [8];
   logic [vic_pkg::DEPTH_W-1:0] depth_q, depth_d, depth_pop;
   logic act_valid;
   logic [2:0] top_idx;
   logic [4:0] act_vec;
   logic [2:0] act_prio;

   // ------------------------------------------------------------
   // source selection and arbitration
   // ------------------------------------------------------------
   irq_source_mux u_mux (
      .sel(src_sel_q),
      .fixed_irq(fixed_irq),
      .dma_term0(dma_term0),
      .dma_term1(dma_term1),
      .logic_irq(logic_irq),
      .line(line)
   );

   irq_prio_arbiter u_arb (
      .req(elig),
      .prio(prio_q),
      .win_valid(win_valid),
      .win_vec(win_vec),
      .win_prio(win_prio)
   );

   assign act_valid = depth_q != '0;
   assign top_idx = 3'(depth_q - 4'h1);
   assign act_vec = act_valid ? stack_vec_q[top_idx] : 5'h00;
   assign act_prio = act_valid ? stack_prio_q[top_idx] : 3'h0;

   always_comb begin
      for (int i = 0; i < vic_pkg::NUM_VEC; i++) begin
         elig[i] = posted_flag_q[i] && enable_q[i]
                   && (depth_q < vic_pkg::DEPTH_W'(vic_pkg::NEST_DEPTH))
                   && (!act_valid ||
                       vic_pkg::higher_prio(prio_q[3*i +: 3], act_prio));
      end
   end

   // ------------------------------------------------------------
   // ahb-lite slave
   // ------------------------------------------------------------
   // zero wait states; a frozen block holds the bus off instead of losing a beat
   assign hreadyout = clk_en;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   always_comb begin
      logic [7:0] ra;
      ra = haddr[7:0];
      rd_word = 32'h0000_0000;
      if (ra[7]) begin
         rd_word = 32'(isr_q[ra[6:2]]);
      end else if (ra == vic_pkg::OFS_ENABLE) begin
         rd_word = enable_q;
      end else if (ra == vic_pkg::OFS_SET_PENDING_FLAG) begin
         rd_word = pending_flag_q;
      end else if (ra == vic_pkg::OFS_CLR_PENDING_FLAG) begin
         rd_word = posted_flag_q;
      end else if (ra == vic_pkg::OFS_ACTIVE) begin
         rd_word[vic_pkg::ACT_DEPTH_POS +: 4] = depth_q;
         rd_word[vic_pkg::ACT_PRIO_POS +: 3] = act_prio;
         rd_word[vic_pkg::ACT_VEC_POS +: 5] = act_vec;
      end else if (ra == vic_pkg::OFS_SRC_LO) begin
         rd_word = src_sel_q[31:0];
      end else if (ra == vic_pkg::OFS_SRC_HI) begin
         rd_word = src_sel_q[63:32];
      end else if (ra >= vic_pkg::OFS_PRIO0 && ra <= vic_pkg::OFS_PRIO3 &&
                   ra[1:0] == 2'h0) begin
         for (int j = 0; j < 8; j++) begin
            rd_word[vic_pkg::PRIO_FLD_W*j +: 3] = prio_q[3*(8*int'(ra[3:2]) + j) +: 3];
         end
      end
   end

   always_comb begin
      logic a_valid;
      a_valid = hsel && htrans[1] && hready;
      wr_pending_flag_d = a_valid && hwrite;
      wr_addr_d = a_valid ? haddr[7:0] : wr_addr_q;
      hrdata_d = (a_valid && !hwrite) ? rd_word : 32'h0000_0000;

      enable_d = enable_q;
      src_sel_d = src_sel_q;
      prio_d = prio_q;
      isr_d = isr_q;
      sw_set = 32'h0000_0000;
      sw_clr = 32'h0000_0000;
      if (wr_pending_flag_q) begin
         if (wr_addr_q[7]) begin
            isr_d[wr_addr_q[6:2]] = hwdata[ISR_AW-1:0];
         end else if (wr_addr_q == vic_pkg::OFS_ENABLE) begin
            enable_d = hwdata;
         end else if (wr_addr_q == vic_pkg::OFS_SET_PENDING_FLAG) begin
            sw_set = hwdata;
         end else if (wr_addr_q == vic_pkg::OFS_CLR_PENDING_FLAG) begin
            sw_clr = hwdata;
         end else if (wr_addr_q == vic_pkg::OFS_SRC_LO) begin
            src_sel_d[31:0] = hwdata;
         end else if (wr_addr_q == vic_pkg::OFS_SRC_HI) begin
            src_sel_d[63:32] = hwdata;
         end else if (wr_addr_q >= vic_pkg::OFS_PRIO0 &&
                      wr_addr_q <= vic_pkg::OFS_PRIO3 && wr_addr_q[1:0] == 2'h0) begin
            for (int j = 0; j < 8; j++) begin
               prio_d[3*(8*int'(wr_addr_q[3:2]) + j) +: 3] =
                  hwdata[vic_pkg::PRIO_FLD_W*j +: 3];
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending_flag_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
         enable_q <= vic_pkg::ENABLE_RST;
         src_sel_q <= {32{vic_pkg::SRC_RST}};
         prio_q <= {32{vic_pkg::PRIO_RST}};
         for (int i = 0; i < vic_pkg::NUM_VEC; i++) begin
            isr_q[i] <= ISR_AW'(vic_pkg::ISR_RST);
         end
      end else if (clk_en) begin
         wr_pending_flag_q <= wr_pending_flag_d;
         wr_addr_q <= wr_addr_d;
         hrdata_q <= hrdata_d;
         enable_q <= enable_d;
         src_sel_q <= src_sel_d;
         prio_q <= prio_d;
         isr_q <= isr_d;
      end
   end

   // ------------------------------------------------------------
   // pending and posted flags
   // ------------------------------------------------------------
   always_comb begin
      logic [31:0] arrive;
      arrive = line & ~line_q;
      // any arrival or software raise beats a clear in the same cycle
      pending_flag_d = (pending_flag_q & ~sw_clr & ~ack_clr) | arrive | sw_set;
      posted_flag_d = (posted_flag_q | pending_flag_q) & ~sw_clr & ~posted_flag_clr;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_q <= 32'h0000_0000;
         pending_flag_q <= 32'h0000_0000;
         posted_flag_q <= 32'h0000_0000;
      end else if (clk_en) begin
         line_q <= line;
         pending_flag_q <= pending_flag_d;
         posted_flag_q <= posted_flag_d;
      end
   end

   // ------------------------------------------------------------
   // request and acknowledge sequence
   // ------------------------------------------------------------
   assign irq_req = state_q == vic_pkg::ST_REQ;
   assign irq_vector = cur_vec_q;
   assign isr_addr = isr_out_q;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      cur_vec_d = cur_vec_q;
      cur_prio_d = cur_prio_q;
      isr_out_d = isr_out_q;
      push = 1'b0;
      ack_clr = 32'h0000_0000;
      posted_flag_clr = 32'h0000_0000;
      case (state_q)
         vic_pkg::ST_IDLE: begin
            if (win_valid) begin
               state_d = vic_pkg::ST_EVAL;
               cnt_d = '0;
            end
         end
         vic_pkg::ST_EVAL: begin
            if (!win_valid) begin
               state_d = vic_pkg::ST_IDLE;
            end else if (cnt_q == vic_pkg::EVAL_LAST) begin
               state_d = vic_pkg::ST_REQ;
               cur_vec_d = win_vec;
               cur_prio_d = win_prio;
               isr_out_d = isr_q[win_vec];
            end else begin
               cnt_d = cnt_q + 3'h1;
            end
         end
         vic_pkg::ST_REQ: begin
            if (irq_acknowledge) begin
               state_d = vic_pkg::ST_CLR_PENDING_FLAG;
            end else if (!posted_flag_q[cur_vec_q] || !enable_q[cur_vec_q]) begin
               // withdrawn by software before the cpu took it
               state_d = vic_pkg::ST_IDLE;
            end
         end
         vic_pkg::ST_CLR_PENDING_FLAG: begin
            ack_clr[cur_vec_q] = 1'b1;
            state_d = vic_pkg::ST_CLR_POSTED_FLAG;
         end
         vic_pkg::ST_CLR_POSTED_FLAG: begin
            posted_flag_clr[cur_vec_q] = 1'b1;
            cnt_d = '0;
            state_d = vic_pkg::ST_BRANCH;
         end
         vic_pkg::ST_BRANCH: begin
            if (cnt_q == vic_pkg::BRANCH_LAST) begin
               push = 1'b1;
               state_d = vic_pkg::ST_IDLE;
            end else begin
               cnt_d = cnt_q + 3'h1;
            end
         end
         default: state_d = vic_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= vic_pkg::ST_IDLE;
         cnt_q <= '0;
         cur_vec_q <= 5'h00;
         cur_prio_q <= 3'h0;
         isr_out_q <= '0;
      end else if (clk_en) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cur_vec_q <= cur_vec_d;
         cur_prio_q <= cur_prio_d;
         isr_out_q <= isr_out_d;
      end
   end

   // ------------------------------------------------------------
   // nesting stack of active routines
   // ------------------------------------------------------------
   always_comb begin
      stack_vec_d = stack_vec_q;
      stack_prio_d = stack_prio_q;
      depth_pop = (isr_complete && act_valid) ? depth_q - 4'h1 : depth_q;
      depth_d = depth_pop;
      // a full stack cannot push: arbitration is already blocked at that depth
      if (push && depth_pop < vic_pkg::DEPTH_W'(vic_pkg::NEST_DEPTH)) begin
         stack_vec_d[depth_pop[2:0]] = cur_vec_q;
         stack_prio_d[depth_pop[2:0]] = cur_prio_q;
         depth_d = depth_pop + 4'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         depth_q <= '0;
         for (int i = 0; i < vic_pkg::NEST_DEPTH; i++) begin
            stack_vec_q[i] <= 5'h00;
            stack_prio_q[i] <= 3'h0;
         end
      end else if (clk_en) begin
         depth_q <= depth_d;
         stack_vec_q <= stack_vec_d;
         stack_prio_q <= stack_prio_d;
      end
   end
endmodule // vectored_interrupt_controller

// ==== verif/vic_properties.sv ====
`timescale 1ns/1ps
module vic_properties #(
   parameter int ISR_AW = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic [1:0] htrans,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic irq_req,
   input wire logic [4:0] irq_vector,
   input wire logic [ISR_AW-1:0] isr_addr,
   input wire logic irq_acknowledge,
   input wire logic isr_complete
);
   // ----
   // routines acknowledged and not yet completed
   // ----
   logic [3:0] open_q;
   logic [3:0] open_d;
   logic push;
   logic pop;
   always_comb begin
      push = irq_req && irq_acknowledge && clk_en;
      pop = isr_complete && clk_en && (open_q != 4'h0);
      open_d = open_q + {3'h0, push} - {3'h0, pop};
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         open_q <= 4'h0;
      end else begin
         open_q <= open_d;
      end
   end
   // ----
   // properties
   // ----
   default clocking dc @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   bus_okay_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   ready_follow_a: assert property (hreadyout == clk_en)
      else $error("ready differs from clock enable");
   eval_gap_a: assert property ($rose(irq_req) |-> !$past(irq_req, 2) && !$past(irq_req, 3))
      else $error("request raised without evaluation time");
   req_stable_a: assert property (
      irq_req && $past(irq_req) |-> $stable(irq_vector) && $stable(isr_addr))
      else $error("vector or address moved during request");
   req_hold_a: assert property (
      irq_req && !irq_acknowledge && !htrans[1] && !$past(htrans[1]) |=> irq_req)
      else $error("request dropped without acknowledge");
   ack_drop_a: assert property (irq_req && irq_acknowledge && clk_en |=> !irq_req)
      else $error("request still high after acknowledge");
   branch_gap_a: assert property (irq_req && irq_acknowledge |=> !irq_req [*8])
      else $error("new request inside branch time");
   nest_limit_a: assert property ($rose(irq_req) |-> open_q < 4'h8)
      else $error("request beyond nesting depth");
endmodule // vic_properties

bind vectored_interrupt_controller vic_properties #(.ISR_AW(ISR_AW)) vic_properties_inst (
   .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .htrans(htrans),
   .hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req), .irq_vector(irq_vector),
   .isr_addr(isr_addr), .irq_acknowledge(irq_acknowledge), .isr_complete(isr_complete)
);

// ==== verif/cpu_model.sv ====
`timescale 1ns/1ps
module cpu_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic irq_req,
   input wire logic [4:0] irq_vector,
   input wire logic [3:0] ack_wait,
   input wire logic ret_cmd,
   output logic irq_acknowledge,
   output logic isr_complete,
   output logic [4:0] last_vec,
   output logic [7:0] taken
);
   // ----
   // acknowledge after ack_wait cycles, slow or prompt
   // ----
   logic [3:0] wait_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_acknowledge <= 1'b0;
         isr_complete <= 1'b0;
         last_vec <= 5'h00;
         taken <= 8'h00;
         wait_q <= 4'h0;
      end else begin
         isr_complete <= ret_cmd;
         if (irq_acknowledge) begin
            irq_acknowledge <= 1'b0;
            wait_q <= 4'h0;
            if (irq_req) begin
               last_vec <= irq_vector;
               taken <= taken + 8'h01;
            end
         end else if (irq_req) begin
            if (wait_q == ack_wait) begin
               irq_acknowledge <= 1'b1;
            end else begin
               wait_q <= wait_q + 4'h1;
            end
         end else begin
            wait_q <= 4'h0;
         end
      end
   end
endmodule // cpu_model

// ==== verif/vectored_interrupt_controller_tb.sv ====
`timescale 1ns/1ps
module vectored_interrupt_controller_tb;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_req, ret_cmd;
   logic irq_acknowledge, isr_complete;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] ack_wait;
   logic [4:0] irq_vector, last_vec;
   logic [7:0] taken;
   logic [15:0] dma_term0, dma_term1, isr_addr;
   logic [31:0] haddr, hwdata, hrdata, fixed_irq, logic_irq, rdat;
   int miscompares;
   int total_checks;
   vectored_interrupt_controller vectored_interrupt_controller_inst (
      .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .fixed_irq(fixed_irq), .dma_term0(dma_term0), .dma_term1(dma_term1),
      .logic_irq(logic_irq), .irq_req(irq_req), .irq_vector(irq_vector),
      .isr_addr(isr_addr), .irq_acknowledge(irq_acknowledge), .isr_complete(isr_complete));
   cpu_model cpu_model_inst (
      .hclk(hclk), .hresetn(hresetn), .irq_req(irq_req), .irq_vector(irq_vector),
      .ack_wait(ack_wait), .ret_cmd(ret_cmd), .irq_acknowledge(irq_acknowledge),
      .isr_complete(isr_complete), .last_vec(last_vec), .taken(taken));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // ----
   // common tasks
   // ----
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic ready_edge();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            miscompares++;
            final_report();
         end
         @(posedge hclk);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      ready_edge();
      htrans <= 2'h0;
      hwdata <= wd;
      ready_edge();
      rdat = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk($sformatf("register %h", a), rdat, exp);
   endtask
   task automatic do_reset();
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask
   // kind: fixed, dma, logic array line
   task automatic raise(input logic [2:0] kind, input logic [4:0] v);
      fixed_irq[v] <= kind[2];
      logic_irq[v] <= kind[0];
      if (v < 5'h10) dma_term0[v[3:0]] <= kind[1];
      else dma_term1[v[3:0]] <= kind[1];
      repeat (2) @(posedge hclk);
      fixed_irq <= 32'h0;
      logic_irq <= 32'h0;
      dma_term0 <= 16'h0;
      dma_term1 <= 16'h0;
      @(posedge hclk);
   endtask
   // margin lets the push land before any completion
   task automatic wait_taken(input logic [7:0] n);
      int i;
      i = 0;
      while (taken !== n) begin
         i++;
         if (i > 80) begin
            miscompares++;
            final_report();
         end
         @(posedge hclk);
      end
      repeat (14) @(posedge hclk);
   endtask
   task automatic ret();
      ret_cmd <= 1'b1;
      @(posedge hclk);
      ret_cmd <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_regs();
      do_reset();
      rd(32'h00, 32'h0);
      rd(32'h0C, 32'h0);
      rd(32'h10, 32'h0);
      rd(32'h2C, 32'h0);
      rd(32'hFC, 32'h0);
      wr(32'h40, 32'hFFFF_FFFF);
      rd(32'h40, 32'h0);
      wr(32'h00, 32'hA5A5_0F0F);
      rd(32'h00, 32'hA5A5_0F0F);
      wr(32'h2C, 32'h0765_4321);
      rd(32'h2C, 32'h0765_4321);
      wr(32'hFC, 32'h0000_BEEF);
      rd(32'hFC, 32'h0000_BEEF);
      $display("t_regs done");
   endtask
   task automatic t_latency();
      int n;
      do_reset();
      wr(32'h94, 32'h0000_1234);
      wr(32'h00, 32'h0000_0020);
      fixed_irq[5] <= 1'b1;
      n = 0;
      while (irq_req !== 1'b1 && n < 20) begin
         @(posedge hclk);
         #1;
         n++;
      end
      chk("edges to request", 32'(n), 32'h5);
      chk("vector", {27'h0, irq_vector}, 32'h5);
      chk("routine address", {16'h0, isr_addr}, 32'h1234);
      @(posedge hclk);
      fixed_irq <= 32'h0;
      wait_taken(8'h01);
      rd(32'h0C, 32'h0000_1005);
      ret();
      rd(32'h0C, 32'h0);
      $display("t_latency done");
   endtask
   task automatic t_order();
      do_reset();
      ack_wait <= 4'h3;
      wr(32'h20, 32'h2000_2000);
      wr(32'h00, 32'h0000_0088);
      for (int i = 0; i < 2; i++) begin
         fixed_irq <= 32'h0000_0088;
         repeat (2) @(posedge hclk);
         fixed_irq <= 32'h0;
         wait_taken(8'(2 * i + 1));
         chk("first", {27'h0, last_vec}, (i == 0) ? 32'h3 : 32'h7);
         chk("no preempt", {24'h0, taken}, 32'(2 * i + 1));
         ret();
         wait_taken(8'(2 * i + 2));
         chk("second", {27'h0, last_vec}, (i == 0) ? 32'h7 : 32'h3);
         ret();
         wr(32'h20, 32'h1000_2000);
      end
      ack_wait <= 4'h0;
      $display("t_order done");
   endtask
   task automatic t_soft();
      do_reset();
      wr(32'h00, 32'h0000_0200);
      wr(32'h04, 32'h0000_0200);
      wait_taken(8'h01);
      chk("soft vector", {27'h0, last_vec}, 32'h9);
      ret();
      wr(32'h04, 32'h0000_0400);
      rd(32'h04, 32'h0000_0400);
      rd(32'h08, 32'h0000_0400);
      wr(32'h08, 32'h0000_0400);
      rd(32'h04, 32'h0);
      wr(32'h00, 32'h0000_0600);
      repeat (14) @(posedge hclk);
      chk("cleared not served", {24'h0, taken}, 32'h1);
      $display("t_soft done");
   endtask
   task automatic t_src();
      logic [4:0] vecs [4];
      logic [2:0] sel [4];
      logic [7:0] k;
      vecs = '{5'd2, 5'd4, 5'd20, 5'd6};
      sel = '{3'b010, 3'b001, 3'b010, 3'b000};
      k = 8'h00;
      do_reset();
      wr(32'h10, 32'h0000_3210);
      wr(32'h14, 32'h0000_0100);
      wr(32'h00, 32'h0010_0054);
      for (int i = 0; i < 4; i++) begin
         raise(~sel[i], vecs[i]);
         repeat (14) @(posedge hclk);
         chk("unselected line", {24'h0, taken}, {24'h0, k});
         if (sel[i] != 3'b000) begin
            raise(sel[i], vecs[i]);
            k++;
            wait_taken(k);
            chk("source", {27'h0, last_vec}, {27'h0, vecs[i]});
            ret();
         end
      end
      $display("t_src done");
   endtask
   task automatic t_nest();
      do_reset();
      wr(32'h2C, 32'h0123_4567);
      wr(32'h00, 32'hFF00_0000);
      for (int i = 0; i < 8; i++) begin
         raise(3'b100, 5'(24 + i));
         wait_taken(8'(i + 1));
         chk("nested", {27'h0, last_vec}, 32'(24 + i));
      end
      rd(32'h0C, 32'h0000_801F);
      raise(3'b100, 5'd24);
      repeat (14) @(posedge hclk);
      chk("less urgent waits", {24'h0, taken}, 32'h8);
      ret();
      rd(32'h0C, 32'h0000_711E);
      $display("t_nest done");
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      fixed_irq = 32'h0;
      logic_irq = 32'h0;
      dma_term0 = 16'h0;
      dma_term1 = 16'h0;
      ack_wait = 4'h0;
      ret_cmd = 1'b0;
      miscompares = 0;
      total_checks = 0;
      t_regs();
      t_latency();
      t_order();
      t_soft();
      t_src();
      t_nest();
      final_report();
   end
endmodule // vectored_interrupt_controller_tb
